/* core/lpd_core.sv */
// Four-channel 8-bit PWM LED sink control with power-on open detection
//
// Notes on behaviour
// RULE1 - Duty per frame is the 8-bit code over 255, MSB weighted 2^7.
// RULE2 - An 8-bit dimming counter runs; output on while count below code.
// RULE3 - With gate active, on for code clocks in each repeating 255-clock frame.
// RULE4 - Pattern repeats until a new code is loaded into the channel latch.
// RULE5 - Code zero is always off, code 255 always on, no switching.
// RULE6 - All outputs start on after reset.
// RULE7 - Open detection runs once after power-up only.
// RULE8 - During detection outputs forced on, feedback out low until feedback in high.
// RULE9 - On detect strobe rising edge, latch per-output open flag from low voltage.
// RULE10 - Feedback passes to next driver only after open flags are latched.
// RULE11 - Open outputs are ignored for supply regulation feedback.
// RULE12 - Feedback out low when any non-open output is below reference.
// RULE13 - Without external clock, internal 100 kHz oscillator is the dimming clock.
// RULE14 - First rising edge on external clock pin switches the source.
// RULE15 - Channels independent; shared dimming clock and output gating.
`timescale 1ns/100ps
module lpd_core
    import lpd_pkg::*;
(
    // Clock and reset
    input  wire logic                      i_clock,
    input  wire logic                      i_rst,
    // Code latch load
    input  wire logic [LPD_CHANNELS-1:0]   i_code_load,
    input  wire logic [LPD_CODE_W-1:0]     i_code_data,
    // Pins and comparators
    input  wire logic                      i_output_gate_in,
    input  wire logic                      i_feedback_chain_in,
    input  wire logic                      i_ext_dimming_clock_in,
    input  wire logic [LPD_CHANNELS-1:0]   i_below_open_threshold,
    input  wire logic [LPD_CHANNELS-1:0]   i_below_feedback_ref,
    // Outputs
    output logic      [LPD_CHANNELS-1:0]   o_sink_on,
    output logic                           o_feedback_chain_out,
    output logic      [LPD_CHANNELS-1:0]   o_open_flags,
    output logic                           o_detect_done
);
    // Two-stage synchronisers for pin and analog inputs
    logic [2+2*LPD_CHANNELS:0] sync1_ff;
    logic [2+2*LPD_CHANNELS:0] sync2_ff;

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end
        else
        begin
            sync1_ff <= {i_below_feedback_ref, i_below_open_threshold,
                         i_ext_dimming_clock_in, i_feedback_chain_in, i_output_gate_in};
            sync2_ff <= sync1_ff;
        end
    end

    logic                    gate_s;
    logic                    fb_in_s;
    logic                    ext_s;
    logic [LPD_CHANNELS-1:0] open_s;
    logic [LPD_CHANNELS-1:0] low_s;

    assign gate_s  = sync2_ff[0];
    assign fb_in_s = sync2_ff[1];
    assign ext_s   = sync2_ff[2];
    assign open_s  = sync2_ff[3 +: LPD_CHANNELS];
    assign low_s   = sync2_ff[3+LPD_CHANNELS +: LPD_CHANNELS];

    lpd_tick_if tick_bus ();

    lpd_clock_sel u_clock_sel (
        .i_clock     (i_clock),
        .i_rst       (i_rst),
        .i_ext_level (ext_s),
        .tick_out    (tick_bus.src)
    );

    // Detection sequencer
    lpd_state_t state_ff;
    logic       strobe_ff;

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            state_ff <= LPD_ST_DETECT;
        else
        begin
            case (state_ff)
                LPD_ST_DETECT: if (fb_in_s) state_ff <= LPD_ST_LATCH; // RULE8
                LPD_ST_LATCH:  state_ff <= LPD_ST_RUN;
                LPD_ST_RUN:    state_ff <= LPD_ST_RUN; // RULE7
                default:       state_ff <= LPD_ST_DETECT;
            endcase
        end
    end

    // Internal open-detect strobe, one pulse
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            strobe_ff <= 1'b0;
        else
            strobe_ff <= (state_ff == LPD_ST_DETECT) & fb_in_s;
    end

    logic [LPD_CHANNELS-1:0] open_ff;

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            open_ff <= '0;
        else if (strobe_ff && state_ff == LPD_ST_LATCH)
            open_ff <= open_s; // RULE9
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            o_detect_done <= 1'b0;
        else
            o_detect_done <= (state_ff == LPD_ST_RUN);
    end

    // Feedback: low while detecting, then low on any non-open low output
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            o_feedback_chain_out <= 1'b0; // RULE8
        else if (state_ff != LPD_ST_RUN)
            o_feedback_chain_out <= 1'b0; // RULE10
        else
            o_feedback_chain_out <= fb_in_s & ~|(low_s & ~open_ff); // RULE11 RULE12
    end

    assign o_open_flags = open_ff;

    // Shared 8-bit frame counter on the dimming clock
    logic [7:0] count_ff;

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            count_ff <= 8'h00;
        else if (tick_bus.tick)
            count_ff <= (count_ff == LPD_FRAME_LAST) ? 8'h00 : count_ff + 8'h01; // RULE2 RULE3
    end

    function automatic logic chan_on(input logic [7:0] code, input logic [7:0] cnt);
        if (code == LPD_CODE_FULL)
            chan_on = 1'b1; // RULE5
        else if (code == LPD_CODE_ZERO)
            chan_on = 1'b0; // RULE5
        else
            chan_on = (cnt < code); // RULE1 RULE2
    endfunction : chan_on

    logic [LPD_CODE_W-1:0] code_ff [LPD_CHANNELS];

    genvar g;
    generate
        for (g = 0; g < LPD_CHANNELS; g++)
        begin : g_chan
            always_ff @(posedge i_clock or posedge i_rst)
            begin
                if (i_rst)
                    code_ff[g] <= LPD_CODE_FULL; // RULE6
                else if (i_code_load[g])
                    code_ff[g] <= i_code_data; // RULE4 RULE15
            end

            always_ff @(posedge i_clock or posedge i_rst)
            begin
                if (i_rst)
                    o_sink_on[g] <= 1'b1; // RULE6
                else if (state_ff != LPD_ST_RUN)
                    o_sink_on[g] <= 1'b1; // RULE8
                else
                    o_sink_on[g] <= gate_s & chan_on(code_ff[g], count_ff); // RULE3 RULE15
            end

            a_full_code_on : assert property (@(posedge i_clock) disable iff (i_rst) // RULE5
                (state_ff == LPD_ST_RUN && gate_s && code_ff[g] == LPD_CODE_FULL)
                |=> o_sink_on[g]) else $error("full code not on");
            a_zero_code_off : assert property (@(posedge i_clock) disable iff (i_rst) // RULE5
                (state_ff == LPD_ST_RUN && code_ff[g] == LPD_CODE_ZERO)
                |=> !o_sink_on[g]) else $error("zero code not off");
            a_pwm_compare : assert property (@(posedge i_clock) disable iff (i_rst) // RULE2
                (state_ff == LPD_ST_RUN && gate_s && code_ff[g] != LPD_CODE_FULL)
                |=> o_sink_on[g] == ($past(count_ff) < $past(code_ff[g])))
                else $error("pwm compare wrong");
            a_detect_forced_on : assert property (@(posedge i_clock) disable iff (i_rst) // RULE8
                (state_ff == LPD_ST_DETECT) |=> o_sink_on[g]) else $error("not forced on");
            a_code_hold : assert property (@(posedge i_clock) disable iff (i_rst) // RULE4
                !i_code_load[g] |=> $stable(code_ff[g]))
                else $error("code changed without load");
        end
    endgenerate

    a_frame_wrap : assert property (@(posedge i_clock) disable iff (i_rst) // RULE3
        (tick_bus.tick && count_ff == LPD_FRAME_LAST) |=> count_ff == 8'h00)
        else $error("frame length wrong");
    a_ext_tick_edge : assert property (@(posedge i_clock) disable iff (i_rst) // RULE14
        (tick_bus.ext_sel && tick_bus.tick) |-> ($past(ext_s) && !$past(ext_s, 2)))
        else $error("external tick without pin edge");
    a_fb_low_detect : assert property (@(posedge i_clock) disable iff (i_rst) // RULE10
        (state_ff != LPD_ST_RUN) |=> !o_feedback_chain_out) else $error("feedback early");
    a_detect_once : assert property (@(posedge i_clock) disable iff (i_rst) // RULE7
        (state_ff == LPD_ST_RUN) |=> state_ff == LPD_ST_RUN) else $error("detection repeated");
    a_latch_seq : assert property (@(posedge i_clock) disable iff (i_rst) // RULE9
        (state_ff == LPD_ST_DETECT && fb_in_s) |=> state_ff == LPD_ST_LATCH ##1
        (o_open_flags == $past(open_s))) else $error("open flags not latched");
    a_open_masked : assert property (@(posedge i_clock) disable iff (i_rst) // RULE11
        (state_ff == LPD_ST_RUN && fb_in_s && (low_s & ~open_ff) == '0)
        |=> o_feedback_chain_out) else $error("open output pulled feedback");
    a_fb_low_ref : assert property (@(posedge i_clock) disable iff (i_rst) // RULE12
        (state_ff == LPD_ST_RUN && (low_s & ~open_ff) != '0)
        |=> !o_feedback_chain_out) else $error("low output did not pull feedback");
endmodule : lpd_core

/* core/lpd_pkg.sv */
// Shared constants and types for the LED dimming driver core
package lpd_pkg;
    localparam int          LPD_CHANNELS     = 4;
    localparam int          LPD_CODE_W       = 8;
    localparam logic [7:0]  LPD_FRAME_LAST   = 8'hFE;
    localparam logic [7:0]  LPD_CODE_ZERO    = 8'h00;
    localparam logic [7:0]  LPD_CODE_FULL    = 8'hFF;
    localparam int          LPD_CLK_HZ       = 40_000_000;
    localparam int          LPD_OSC_HZ       = 100_000;
    localparam int          LPD_OSC_HALF_CYC = LPD_CLK_HZ / (2 * LPD_OSC_HZ);
    localparam logic [7:0]  LPD_OSC_HALF_LAST = 8'(LPD_OSC_HALF_CYC - 1);

    typedef enum logic [1:0] {
        LPD_ST_DETECT,
        LPD_ST_LATCH,
        LPD_ST_RUN
    } lpd_state_t;
endpackage : lpd_pkg

/* core/lpd_tick_if.sv */
// Dimming clock tick carrier between the top and the clock selector
`timescale 1ns/100ps
interface lpd_tick_if;
    logic tick;
    logic ext_sel;
    modport src (output tick, output ext_sel);
    modport dst (input tick, input ext_sel);
endinterface : lpd_tick_if

/* core/lpd_clock_sel.sv */
// Dimming clock source: internal oscillator or external clock pin
`timescale 1ns/100ps
module lpd_clock_sel
    import lpd_pkg::*;
(
    // Clock and reset
    input  wire logic   i_clock,
    input  wire logic   i_rst,
    // Synchronised external clock level
    input  wire logic   i_ext_level,
    // Tick out
    lpd_tick_if.src     tick_out
);
    logic [7:0] div_ff;
    logic       osc_ff;
    logic       ext_prev_ff;
    logic       ext_sel_ff;
    logic       tick_ff;
    logic       ext_rise;

    assign ext_rise = i_ext_level & ~ext_prev_ff;

    // Internal oscillator toggles every half period
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            div_ff <= 8'h00;
            osc_ff <= 1'b0;
        end
        else if (div_ff == LPD_OSC_HALF_LAST)
        begin
            div_ff <= 8'h00;
            osc_ff <= ~osc_ff;
        end
        else
        begin
            div_ff <= div_ff + 8'h01;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            ext_prev_ff <= 1'b0;
        else
            ext_prev_ff <= i_ext_level;
    end

    // First external rising edge selects the pin for good
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            ext_sel_ff <= 1'b0;
        else if (ext_rise)
            ext_sel_ff <= 1'b1; // RULE14
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            tick_ff <= 1'b0;
        else if (ext_sel_ff)
            tick_ff <= ext_rise; // RULE14
        else
            tick_ff <= (div_ff == LPD_OSC_HALF_LAST) & ~osc_ff; // RULE13
    end

    assign tick_out.tick    = tick_ff;
    assign tick_out.ext_sel = ext_sel_ff;

    a_ext_sel_sticky : assert property (@(posedge i_clock) disable iff (i_rst) // RULE14
        ext_sel_ff |=> ext_sel_ff) else $error("external clock select dropped");
    a_ext_sel_cause : assert property (@(posedge i_clock) disable iff (i_rst) // RULE14
        $rose(ext_sel_ff) |-> $past(ext_rise)) else $error("select without edge");
    a_osc_tick_rate : assert property (@(posedge i_clock) disable iff (i_rst) // RULE13
        (!ext_sel_ff && tick_ff) |=> !tick_ff [*8]) else $error("oscillator tick too fast");
endmodule : lpd_clock_sel

/* bench/lpd_led_model.sv */
// LED string model: comparator levels seen behind each sink output
`timescale 1ns/100ps
module lpd_led_model
    import lpd_pkg::*;
(
    // Sink state from the driver
    input  wire logic [LPD_CHANNELS-1:0] i_sink_on,
    // String condition
    input  wire logic [LPD_CHANNELS-1:0] i_open_mask,
    input  wire logic [LPD_CHANNELS-1:0] i_weak_mask,
    // Comparator levels
    output logic      [LPD_CHANNELS-1:0] o_below_open,
    output logic      [LPD_CHANNELS-1:0] o_below_ref
);
    // Off sinks float up to the supply, so nothing trips
    assign o_below_open = i_sink_on & i_open_mask;
    assign o_below_ref  = i_sink_on & (i_open_mask | i_weak_mask);
endmodule : lpd_led_model

/* bench/lpd_core_tb_top.sv */
// Self-checking bench for the LED dimming driver core
`timescale 1ns/100ps
module lpd_core_tb_top;
    import lpd_pkg::*;
    localparam int TICK_HALF = 80;
    localparam int TICK_CYC  = 2 * TICK_HALF;
    localparam int FRAME_CYC = 255 * TICK_CYC;
    localparam int MAX_CYC   = 60000;

    logic                    i_clock     = 1'b0;
    logic                    i_rst       = 1'b1;
    logic [LPD_CHANNELS-1:0] i_code_load = '0;
    logic [LPD_CODE_W-1:0]   i_code_data = '0;
    logic                    gate        = 1'b0;
    logic                    fb_in       = 1'b0;
    logic                    ext_clk     = 1'b0;
    logic [LPD_CHANNELS-1:0] open_mask   = 4'h5;
    logic [LPD_CHANNELS-1:0] weak_mask   = '0;
    logic [LPD_CHANNELS-1:0] below_open;
    logic [LPD_CHANNELS-1:0] below_ref;
    logic [LPD_CHANNELS-1:0] sink_on;
    logic [LPD_CHANNELS-1:0] open_flags;
    logic                    fb_out;
    logic                    done;
    int                      err_count       = 0;
    int                      samples_checked = 0;
    int                      cycles          = 0;

    lpd_core dut (
        .i_clock(i_clock), .i_rst(i_rst), .i_code_load(i_code_load),
        .i_code_data(i_code_data), .i_output_gate_in(gate), .i_feedback_chain_in(fb_in),
        .i_ext_dimming_clock_in(ext_clk), .i_below_open_threshold(below_open),
        .i_below_feedback_ref(below_ref), .o_sink_on(sink_on),
        .o_feedback_chain_out(fb_out), .o_open_flags(open_flags), .o_detect_done(done)
    );

    lpd_led_model leds (
        .i_sink_on(sink_on), .i_open_mask(open_mask), .i_weak_mask(weak_mask),
        .o_below_open(below_open), .o_below_ref(below_ref)
    );

    always #12.5 i_clock = ~i_clock;

    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles == MAX_CYC)
        begin
            err_count++;
            conclude();
        end
    end

    task automatic step(input int n);
        repeat (n)
        begin
            @(posedge i_clock);
            #1;
        end
    endtask : step

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    // Power-up detection, flag latch, single run
    task automatic t_detect();
        int n;
        step(4);
        check("sink_on detect", 32'(sink_on), 32'hF);
        check("fb_out detect", 32'(fb_out), 32'h0);
        check("done early", 32'(done), 32'h0);
        gate = 1'b1;
        fb_in = 1'b1;
        n = 0;
        while (done !== 1'b1 && n < 20)
        begin
            step(1);
            n++;
        end
        check("open_flags", 32'(open_flags), 32'h5);
        step(2);
        check("fb_out passed", 32'(fb_out), 32'h1);
        fb_in = 1'b0;
        open_mask = '0;
        step(6);
        fb_in = 1'b1;
        step(10);
        check("flags kept", 32'(open_flags), 32'h5);
        check("done kept", 32'(done), 32'h1);
    endtask : t_detect

    // Supply feedback with open and weak strings
    task automatic t_feedback();
        open_mask = 4'h5;
        step(6);
        check("fb_out open ignored", 32'(fb_out), 32'h1);
        weak_mask = 4'h2;
        step(6);
        check("fb_out weak", 32'(fb_out), 32'h0);
        weak_mask = '0;
        fb_in = 1'b0;
        step(6);
        check("fb_out chain low", 32'(fb_out), 32'h0);
        fb_in = 1'b1;
        step(6);
        check("fb_out chain high", 32'(fb_out), 32'h1);
    endtask : t_feedback

    // Shared output gating
    task automatic t_gate();
        gate = 1'b0;
        step(6);
        check("sink_on gated", 32'(sink_on), 32'h0);
        gate = 1'b1;
        step(6);
        check("sink_on ungated", 32'(sink_on), 32'hF);
    endtask : t_gate

    // Internal dimming clock: one count step per oscillator period
    task automatic t_osc();
        int n;
        int t_first;
        i_code_load = 4'h1;
        i_code_data = 8'h01;
        step(1);
        i_code_load = 4'h2;
        i_code_data = 8'h02;
        step(1);
        i_code_load = '0;
        step(2);
        check("osc ch0 on", 32'(sink_on[0]), 32'h1);
        n = 0;
        while (sink_on[0] === 1'b1 && n < 600)
        begin
            step(1);
            n++;
        end
        t_first = cycles;
        n = 0;
        while (sink_on[1] === 1'b1 && n < 600)
        begin
            step(1);
            n++;
        end
        check("osc period", 32'(cycles - t_first), 32'(LPD_CLK_HZ / LPD_OSC_HZ));
    endtask : t_osc

    // One full frame on the external dimming clock, on-cycles per channel
    task automatic t_pwm();
        int         on_cnt [LPD_CHANNELS] = '{default: 0};
        logic [7:0] codes  [LPD_CHANNELS] = '{8'h00, 8'h07, 8'hFE, 8'hFF};
        for (int c = 0; c < LPD_CHANNELS; c++)
        begin
            i_code_load = 4'(1 << c);
            i_code_data = codes[c];
            step(1);
        end
        i_code_load = '0;
        for (int k = 0; k < 2 * TICK_CYC + FRAME_CYC; k++)
        begin
            if (k % TICK_HALF == 0)
                ext_clk = ~ext_clk;
            for (int c = 0; c < LPD_CHANNELS; c++)
                if (k >= 2 * TICK_CYC && sink_on[c] === 1'b1)
                    on_cnt[c]++;
            step(1);
        end
        for (int c = 0; c < LPD_CHANNELS; c++)
            check("duty", 32'(on_cnt[c]), codes[c] * TICK_CYC);
    endtask : t_pwm

    initial
    begin
        step(12);
        i_rst = 1'b0;
        t_detect();
        t_feedback();
        t_gate();
        t_osc();
        t_pwm();
        conclude();
    end
endmodule : lpd_core_tb_top
